// ### design/timer_command_and_sync_busy.sv
`timescale 1ns/1ps
module timer_command_and_sync_busy
   import tc_cmd_pkg::*;
#(
   parameter int PRESCALE = tc_cmd_pkg::PRESCALE_DEFAULT
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tc_cmd_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic counter_running,
   output logic wrap_event
);
   import tc_cmd_pkg::*;

   localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

   ////////////////////////////////////////////////////////////////////////////
   // State of the block except the busy flags, which sit in u_busy
   typedef struct packed {
      logic [PW-1:0] presc;       // Core tick divider
      logic [2:0] cmd_pend;       // Issued command awaiting its tick
      logic dir;                  // Count down when set
      logic buffer_update_lock;   // Buffer update lock
      logic single_run;           // One-shot mode
      logic enable_req;           // Enable as written by software
      logic enable;               // Enable as seen by the core
      logic soft_reset_pend;      // Soft reset awaiting its tick
      logic running;              // Counter running
      logic wrap_ev;              // Wrap pulse
      logic [CNT_W-1:0] count;    // Core counter
      logic [CNT_W-1:0] snap;     // Counter value visible to the bus
      logic [CNT_W-1:0] cycle_length;      // Active cycle length
      logic [CNT_W-1:0] per_buf;  // Cycle length shadow
      logic per_bv;               // Cycle length shadow valid
      logic [CNT_W-1:0] cc;       // Active compare value
      logic [CNT_W-1:0] cc_buf;   // Compare shadow
      logic cc_bv;                // Compare shadow valid
      logic pready;               // APB ready
      logic pslverr;              // APB error
      logic [31:0] prdata;        // APB read data
   } state_t;

   localparam state_t ST_RST = '{cycle_length: CYCLE_LENGTH_RESET, count: COUNT_RESET, cc: CC_RESET, default: '0};

   state_t st_ff;
   state_t nxt_st;
   logic tick;                    // One-cycle core clock tick
   logic wrap;                    // Counter wraps at this tick
   logic upd;                     // Shadow to active transfer at this tick
   logic counting;                // Counter advances at this tick
   logic setup;                   // APB setup phase
   logic wr_acc;                  // APB write takes effect
   logic [7:0] idx;               // Register index from address
   logic mapped;                  // Address hits a register
   logic [2:0] wcmd;              // Command field of write data
   logic [31:0] rd_val;           // Read mux
   logic [BUSY_N-1:0] busy_set;
   logic [BUSY_N-1:0] busy_clr;
   logic [BUSY_N-1:0] busy;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   assign tick = (st_ff.presc == PW'(PRESCALE - 1));
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite && st_ff.pready;
   assign idx = paddr[9:2];
   assign wcmd = pwdata[CB_CMD_MSB:CB_CMD_LSB];
   assign counting = st_ff.enable && st_ff.running &&
                     (st_ff.cmd_pend != CMD_RETRIGGER) && (st_ff.cmd_pend != CMD_STOP);
   // Overflow counting up at the cycle length, underflow counting down at zero
   assign wrap = tick && counting && (st_ff.dir ? (st_ff.count == '0) : (st_ff.count == st_ff.cycle_length));
   // Forced update ignores the lock; hardware update honours it
   assign upd = tick && !st_ff.soft_reset_pend &&
                ((st_ff.cmd_pend == CMD_UPDATE) || (wrap && !st_ff.buffer_update_lock));

   // Address map; unaligned or out of range accesses are errors
   always_comb begin
      mapped = 1'b0;
      if ((paddr[1:0] == 2'b00) && (paddr[APB_AW-1:10] == '0)) begin
         case (idx)
            IDX_CTRLA, IDX_CTRLBCLR, IDX_CTRLBSET, IDX_STATUS,
            IDX_SYNCBUSY, IDX_COUNT, IDX_CYCLE_LENGTH, IDX_CC: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   end

   // Read mux; narrower registers sit in the low bits
   always_comb begin
      rd_val = '0;
      if (mapped) begin
         case (idx)
            IDX_CTRLA: begin
               rd_val[CTRLA_SOFT_RESET_BIT] = st_ff.soft_reset_pend;
               rd_val[CTRLA_EN_BIT] = st_ff.enable_req;
            end
            IDX_CTRLBCLR, IDX_CTRLBSET: begin
               rd_val[CB_CMD_MSB:CB_CMD_LSB] = st_ff.cmd_pend;
               rd_val[CB_SINGLE_RUN_BIT] = st_ff.single_run;
               rd_val[CB_UPDATE_LOCK_BIT] = st_ff.buffer_update_lock;
               rd_val[CB_DIR_BIT] = st_ff.dir;
            end
            IDX_STATUS: begin
               rd_val[ST_PERBV_BIT] = st_ff.per_bv;
               rd_val[ST_CCBV_BIT] = st_ff.cc_bv;
            end
            IDX_SYNCBUSY: rd_val[BUSY_N-1:0] = busy;
            IDX_COUNT: rd_val[CNT_W-1:0] = st_ff.snap;
            IDX_CYCLE_LENGTH: rd_val[CNT_W-1:0] = st_ff.cycle_length;
            IDX_CC: rd_val[CNT_W-1:0] = st_ff.cc;
            default: rd_val = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state: core tick first, then bus writes, so a write wins a tie
   always_comb begin
      nxt_st = st_ff;
      busy_set = '0;
      nxt_st.presc = tick ? '0 : PW'(st_ff.presc + 1'b1);
      nxt_st.wrap_ev = 1'b0;
      if (tick) begin
         if (st_ff.soft_reset_pend) begin
            // Soft reset lands in the core; everything returns to reset values
            nxt_st = ST_RST;
         end else begin
            nxt_st.enable = st_ff.enable_req;
            nxt_st.cmd_pend = CMD_NONE;
            // Pending command runs on this tick
            case (st_ff.cmd_pend)
               CMD_RETRIGGER: begin
                  nxt_st.running = 1'b1;
                  nxt_st.count = st_ff.dir ? st_ff.cycle_length : '0;
               end
               CMD_STOP: nxt_st.running = 1'b0;
               CMD_COUNT_RESAMPLE: nxt_st.snap = st_ff.count;
               default: ;
            endcase
            // Counter step with wrap
            if (counting) begin
               if (wrap) begin
                  nxt_st.count = st_ff.dir ? st_ff.cycle_length : '0;
                  nxt_st.wrap_ev = 1'b1;
                  // One-shot halts after the wrap; otherwise keep counting
                  if (st_ff.single_run) begin
                     nxt_st.running = 1'b0;
                  end
               end else if (st_ff.dir) begin
                  nxt_st.count = CNT_W'(st_ff.count - 1'b1);
               end else begin
                  nxt_st.count = CNT_W'(st_ff.count + 1'b1);
               end
            end
            // Shadow transfer; only valid shadows are copied
            if (upd) begin
               if (st_ff.per_bv) begin
                  nxt_st.cycle_length = st_ff.per_buf;
               end
               if (st_ff.cc_bv) begin
                  nxt_st.cc = st_ff.cc_buf;
               end
               nxt_st.per_bv = 1'b0;
               nxt_st.cc_bv = 1'b0;
            end
         end
      end

      // APB slave: one wait-free access phase, data registered in setup
      nxt_st.pready = setup;
      nxt_st.pslverr = setup && !mapped;
      nxt_st.prdata = setup ? rd_val : '0;
      if (wr_acc && mapped) begin
         case (idx)
            IDX_CTRLA: begin
               if (pwdata[CTRLA_SOFT_RESET_BIT]) begin
                  nxt_st.soft_reset_pend = 1'b1;
                  busy_set[SB_SOFT_RESET] = 1'b1;
               end
               nxt_st.enable_req = pwdata[CTRLA_EN_BIT];
               busy_set[SB_ENABLE] = 1'b1;
            end
            IDX_CTRLBSET: begin
               // Ones set, zeros leave bits alone
               nxt_st.dir = st_ff.dir | pwdata[CB_DIR_BIT];
               nxt_st.buffer_update_lock = st_ff.buffer_update_lock | pwdata[CB_UPDATE_LOCK_BIT];
               nxt_st.single_run = st_ff.single_run | pwdata[CB_SINGLE_RUN_BIT];
               busy_set[SB_CONTROL_B] = 1'b1;
            end
            IDX_CTRLBCLR: begin
               // Ones clear, zeros leave bits alone
               nxt_st.dir = st_ff.dir & ~pwdata[CB_DIR_BIT];
               nxt_st.buffer_update_lock = st_ff.buffer_update_lock & ~pwdata[CB_UPDATE_LOCK_BIT];
               nxt_st.single_run = st_ff.single_run & ~pwdata[CB_SINGLE_RUN_BIT];
               busy_set[SB_CONTROL_B] = 1'b1;
            end
            IDX_STATUS: begin
               // Write one clears a shadow-valid flag
               if (pwdata[ST_PERBV_BIT]) begin
                  nxt_st.per_bv = 1'b0;
               end
               if (pwdata[ST_CCBV_BIT]) begin
                  nxt_st.cc_bv = 1'b0;
                  busy_set[SB_STATUS] = 1'b1;
               end
            end
            IDX_CYCLE_LENGTH: begin
               nxt_st.per_buf = pwdata[CNT_W-1:0];
               nxt_st.per_bv = 1'b1;
               busy_set[SB_CYCLE_LENGTH] = 1'b1;
            end
            IDX_CC: begin
               nxt_st.cc_buf = pwdata[CNT_W-1:0];
               nxt_st.cc_bv = 1'b1;
               busy_set[SB_CC] = 1'b1;
            end
            default: ;
         endcase
         // Both control-B views carry the command; code zero is ignored
         if (((idx == IDX_CTRLBSET) || (idx == IDX_CTRLBCLR)) && (wcmd != CMD_NONE)) begin
            nxt_st.cmd_pend = wcmd;
            if (wcmd == CMD_COUNT_RESAMPLE) begin
               busy_set[SB_COUNT] = 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Busy clears; the bank lets a set in the same cycle win
   always_comb begin
      busy_clr = '0;
      busy_clr[SB_SOFT_RESET] = tick;
      busy_clr[SB_ENABLE] = tick;
      busy_clr[SB_CONTROL_B] = tick;
      busy_clr[SB_STATUS] = tick;
      busy_clr[SB_COUNT] = tick && (st_ff.cmd_pend == CMD_COUNT_RESAMPLE);
      busy_clr[SB_CYCLE_LENGTH] = tick || upd || (st_ff.per_bv && !nxt_st.per_bv);
      busy_clr[SB_CC] = upd || (st_ff.cc_bv && !nxt_st.cc_bv);
   end

   busy_flag_bank #(
      .N(BUSY_N)
   ) u_busy (
      .clk(clk),
      .arst_n(arst_n),
      .set_req(busy_set),
      .clr_req(busy_clr),
      .busy(busy)
   );

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign counter_running = st_ff.running;
   assign wrap_event = st_ff.wrap_ev;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   localparam int CMD_LIMIT = CMD_WAIT; // Local copy, so the delay bound is a constant of this file

   property p_cmd_done;
      $rose(st_ff.cmd_pend != CMD_NONE) |-> ##[1:CMD_LIMIT] (st_ff.cmd_pend == CMD_NONE);
   endproperty
   a_cmd_done: assert property (p_cmd_done) else $error("command never completed");

   property p_retrigger;
      tick && !st_ff.soft_reset_pend && (st_ff.cmd_pend == CMD_RETRIGGER) |=> counter_running;
   endproperty
   a_retrigger: assert property (p_retrigger) else $error("retrigger did not start counter");

   property p_stop;
      tick && !st_ff.soft_reset_pend && (st_ff.cmd_pend == CMD_STOP) |=> !counter_running;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not halt counter");

   property p_lock;
      wrap && st_ff.buffer_update_lock && (st_ff.cmd_pend == CMD_NONE)
         |=> (st_ff.cycle_length == $past(st_ff.cycle_length)) && $stable(st_ff.cc);
   endproperty
   a_lock: assert property (p_lock) else $error("locked update changed active value");

   property p_single_run;
      wrap && st_ff.single_run && (st_ff.cmd_pend == CMD_NONE) |=> !counter_running ##1 !wrap_event;
   endproperty
   a_single_run: assert property (p_single_run) else $error("one-shot kept running");

   property p_count_resample_order;
      tick && !st_ff.soft_reset_pend && (st_ff.cmd_pend == CMD_COUNT_RESAMPLE) && !wr_acc
         |=> (st_ff.snap == $past(st_ff.count)) && !busy[SB_COUNT];
   endproperty
   a_count_resample_order: assert property (p_count_resample_order) else $error("count snapshot or busy wrong");

   property p_control_b_reg_busy;
      wr_acc && mapped && ((idx == IDX_CTRLBSET) || (idx == IDX_CTRLBCLR)) |=> busy[SB_CONTROL_B];
   endproperty
   a_control_b_reg_busy: assert property (p_control_b_reg_busy) else $error("control-B busy not set");

   property p_single_run_keep;
      wr_acc && mapped && (idx == IDX_CTRLBSET) && st_ff.single_run |=> st_ff.single_run;
   endproperty
   a_single_run_keep: assert property (p_single_run_keep) else $error("set view cleared one-shot");

   property p_none_cmd;
      wr_acc && mapped && (idx == IDX_CTRLBSET) && (wcmd == CMD_NONE) && (st_ff.cmd_pend == CMD_NONE)
         |=> (st_ff.cmd_pend == CMD_NONE);
   endproperty
   a_none_cmd: assert property (p_none_cmd) else $error("code zero issued a command");

   property p_cc_busy_clear;
      st_ff.cc_bv && !nxt_st.cc_bv && !(wr_acc && (idx == IDX_CC)) |=> !busy[SB_CC];
   endproperty
   a_cc_busy_clear: assert property (p_cc_busy_clear) else $error("compare busy stuck");

endmodule

// ### common/tc_cmd_pkg.sv
package tc_cmd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and default sizes
   localparam int APB_AW = 12;           // APB byte address width
   localparam int CNT_W = 16;            // Counter and cycle-length width
   localparam int BUSY_N = 7;            // Number of sync-busy flags in use
   localparam int PRESCALE_DEFAULT = 4;  // Bus clocks per core tick
   localparam int CMD_WAIT = 64;         // Upper bound on command execution (needs PRESCALE <= 64)

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRLA = 8'h00;
   localparam logic [7:0] IDX_CTRLBCLR = 8'h04;
   localparam logic [7:0] IDX_CTRLBSET = 8'h05;
   localparam logic [7:0] IDX_STATUS = 8'h0B;
   localparam logic [7:0] IDX_SYNCBUSY = 8'h10;
   localparam logic [7:0] IDX_COUNT = 8'h14;
   localparam logic [7:0] IDX_CYCLE_LENGTH = 8'h1B;
   localparam logic [7:0] IDX_CC = 8'h1C;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRLA_SOFT_RESET_BIT = 0;
   localparam int CTRLA_EN_BIT = 1;
   localparam int CB_DIR_BIT = 0;
   localparam int CB_UPDATE_LOCK_BIT = 1;
   localparam int CB_SINGLE_RUN_BIT = 2;
   localparam int CB_CMD_LSB = 5;
   localparam int CB_CMD_MSB = 7;
   localparam int ST_PERBV_BIT = 3;
   localparam int ST_CCBV_BIT = 4;
   localparam int SB_SOFT_RESET = 0;
   localparam int SB_ENABLE = 1;
   localparam int SB_CONTROL_B = 2;
   localparam int SB_STATUS = 3;
   localparam int SB_COUNT = 4;
   localparam int SB_CYCLE_LENGTH = 5;
   localparam int SB_CC = 6;

   ////////////////////////////////////////////////////////////////////////////
   // Command codes
   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_RETRIGGER = 3'h1;
   localparam logic [2:0] CMD_STOP = 3'h2;
   localparam logic [2:0] CMD_UPDATE = 3'h3;
   localparam logic [2:0] CMD_COUNT_RESAMPLE = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] CONTROL_B_REG_RESET = 8'h00;
   localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] CYCLE_LENGTH_RESET = 16'hFFFF;
   localparam logic [CNT_W-1:0] CC_RESET = 16'h0000;

endpackage

// ### design/busy_flag_bank.sv
`timescale 1ns/1ps
module busy_flag_bank #(
   parameter int N = 7
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [N-1:0] set_req,
   input wire logic [N-1:0] clr_req,
   output logic [N-1:0] busy
);

   // State of the bank
   typedef struct packed {
      logic [N-1:0] flag;
   } bank_t;

   bank_t st_ff;
   bank_t nxt_st;
   logic [N-1:0] nxt_flag; // Per-bit next value

   ////////////////////////////////////////////////////////////////////////////
   // One set-dominant flag per bit; a set in the clear cycle is never lost
   for (genvar i = 0; i < N; i++) begin : g_flag
      assign nxt_flag[i] = set_req[i] | (st_ff.flag[i] & ~clr_req[i]);
   end

   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.flag = nxt_flag;
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy = st_ff.flag;

endmodule

// ### verif/test_timer_command_and_sync_busy.sv
`timescale 1ns/1ps
module test_timer_command_and_sync_busy;
   import tc_cmd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Signals and bookkeeping
   localparam int P = 8; // Slow ticks leave room to probe busy flags between two ticks
   logic clk;
   logic arst_n; // Asynchronous reset, active low
   logic psel;
   logic penable;
   logic pwrite;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic counter_running;
   logic wrap_event;
   int n_fail = 0; // Mismatches seen
   int checked = 0; // Comparisons made
   int cyc = 0; // Bus clocks since reset release, tracks the tick phase
   logic [31:0] rdat; // Last read data
   logic rerr; // Last slave error

   timer_command_and_sync_busy #(.PRESCALE(P)) dut_u (
      .clk(clk),
      .arst_n(arst_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .counter_running(counter_running),
      .wrap_event(wrap_event)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock and phase counter
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Counts edges after release so scenarios can start right after a tick
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cyc <= 0;
      end else begin
         cyc <= cyc + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus and checking tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // A slave that never answers counts as a failure
      if (n >= 20) begin
         n_fail++;
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      xfer(1'b1, {2'b00, idx, 2'b00}, d);
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000);
      chk(rdat, exp);
   endtask

   // Reads one busy flag and compares it
   task automatic sb(input int b, input logic e);
      xfer(1'b0, {2'b00, IDX_SYNCBUSY, 2'b00}, 32'h0000_0000);
      chk({31'h0, rdat[b]}, {31'h0, e});
   endtask

   // Returns just after a core tick edge
   task automatic align();
      do @(posedge clk); while ((cyc + 1) % P != 0);
   endtask

   // Waits for a wrap pulse with a bound
   task automatic wait_wrap();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wrap_event !== 1'b1 && n < 300);
      if (n >= 300) begin
         n_fail++;
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog: the sequence needs a few hundred clocks
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0000_0000;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      // Reset values of the register table
      rchk(IDX_CTRLBSET, {24'h0, CONTROL_B_REG_RESET});
      rchk(IDX_SYNCBUSY, 32'h0000_0000);
      rchk(IDX_CYCLE_LENGTH, {16'h0, CYCLE_LENGTH_RESET});
      rchk(IDX_CC, {16'h0, CC_RESET});
      // Unmapped word: error response, zero data
      xfer(1'b0, 12'h0FC, 32'h0000_0000);
      chk({31'h0, rerr}, 32'h0000_0001);
      chk(rdat, 32'h0000_0000);
      // Set view write shows in clear view, control-B busy spans one tick
      align();
      wr(IDX_CTRLBSET, 32'h0000_0004);
      sb(SB_CONTROL_B, 1'b1);
      repeat (P) @(posedge clk);
      sb(SB_CONTROL_B, 1'b0);
      rchk(IDX_CTRLBCLR, 32'h0000_0004);
      wr(IDX_CTRLBSET, 32'h0000_0000);
      repeat (P) @(posedge clk);
      rchk(IDX_CTRLBCLR, 32'h0000_0004);
      chk({31'h0, counter_running}, 32'h0000_0000);
      wr(IDX_CTRLBCLR, 32'h0000_0004);
      // Count down, retrigger loads the cycle length, then snapshot it
      wr(IDX_CTRLBSET, 32'h0000_0001);
      wr(IDX_CTRLBSET, {24'h0, CMD_RETRIGGER, 5'h00});
      repeat (P + 2) @(posedge clk);
      chk({31'h0, counter_running}, 32'h0000_0001);
      rchk(IDX_CTRLBSET, 32'h0000_0001);
      align();
      wr(IDX_CTRLBSET, {24'h0, CMD_COUNT_RESAMPLE, 5'h00});
      sb(SB_COUNT, 1'b1);
      repeat (P) @(posedge clk);
      sb(SB_COUNT, 1'b0);
      rchk(IDX_COUNT, {16'h0, CYCLE_LENGTH_RESET});
      wr(IDX_CTRLBSET, {24'h0, CMD_STOP, 5'h00});
      repeat (P + 2) @(posedge clk);
      chk({31'h0, counter_running}, 32'h0000_0000);
      wr(IDX_CTRLBCLR, 32'h0000_0001);
      // Shadow writes and a forced update
      align();
      wr(IDX_CYCLE_LENGTH, 32'h0000_0003);
      sb(SB_CYCLE_LENGTH, 1'b1);
      wr(IDX_CC, 32'h0000_0002);
      repeat (P) @(posedge clk);
      sb(SB_CYCLE_LENGTH, 1'b0);
      sb(SB_CC, 1'b1);
      rchk(IDX_STATUS, 32'h0000_0018);
      wr(IDX_CTRLBSET, {24'h0, CMD_UPDATE, 5'h00});
      repeat (P + 2) @(posedge clk);
      sb(SB_CC, 1'b0);
      rchk(IDX_CYCLE_LENGTH, 32'h0000_0003);
      rchk(IDX_CC, 32'h0000_0002);
      // Clearing the compare valid flag drops compare busy, raises status busy
      wr(IDX_CC, 32'h0000_0007);
      align();
      wr(IDX_STATUS, 32'h0000_0010);
      sb(SB_CC, 1'b0);
      sb(SB_STATUS, 1'b1);
      repeat (P) @(posedge clk);
      sb(SB_STATUS, 1'b0);
      // Enable crossing
      align();
      wr(IDX_CTRLA, 32'h0000_0002);
      sb(SB_ENABLE, 1'b1);
      repeat (P) @(posedge clk);
      sb(SB_ENABLE, 1'b0);
      // One-shot stops at the first wrap
      wr(IDX_CTRLBSET, 32'h0000_0004);
      wr(IDX_CTRLBSET, {24'h0, CMD_RETRIGGER, 5'h00});
      wait_wrap();
      repeat (2) @(posedge clk);
      chk({31'h0, counter_running}, 32'h0000_0000);
      // Free running keeps going over two wraps
      wr(IDX_CTRLBCLR, 32'h0000_0004);
      wr(IDX_CTRLBSET, {24'h0, CMD_RETRIGGER, 5'h00});
      wait_wrap();
      wait_wrap();
      chk({31'h0, counter_running}, 32'h0000_0001);
      // Locked wraps must not copy the new cycle length
      wr(IDX_CTRLBSET, 32'h0000_0002);
      wr(IDX_CYCLE_LENGTH, 32'h0000_0005);
      wait_wrap();
      wait_wrap();
      rchk(IDX_CYCLE_LENGTH, 32'h0000_0003);
      wr(IDX_CTRLBCLR, 32'h0000_0002);
      wait_wrap();
      wait_wrap();
      rchk(IDX_CYCLE_LENGTH, 32'h0000_0005);
      // Soft reset last, since it returns the core state to reset values; one-shot set first so the reset has work to undo
      wr(IDX_CTRLBSET, 32'h0000_0004);
      rchk(IDX_CTRLBCLR, 32'h0000_0004);
      align();
      wr(IDX_CTRLA, 32'h0000_0001);
      sb(SB_SOFT_RESET, 1'b1);
      repeat (P) @(posedge clk);
      sb(SB_SOFT_RESET, 1'b0);
      rchk(IDX_CTRLBCLR, 32'h0000_0000);
      rchk(IDX_CYCLE_LENGTH, {16'h0, CYCLE_LENGTH_RESET});
      chk({31'h0, counter_running}, 32'h0000_0000);
      end_sim();
   end
endmodule
